/* design/isc_asin_core.sv */
// arc sine of a magnitude in Q1.16, result in Q2.16, one cycle after start
// assumes start is a one-cycle pulse and x_mag never exceeds 1.0
`timescale 1ns/1ns
module isc_asin_core (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        start,
	input  wire logic [16:0] x_mag,
	output logic      [17:0] y_mag,
	output logic             done
);
	import isc_pkg::*;

	typedef struct packed {
		logic [17:0] y;
		logic        done;
	} isc_core_s;

	isc_core_s   st_reg;
	isc_core_s   st_next;
	logic [3:0]  seg;
	logic [11:0] frac;
	logic [17:0] lo;
	logic [17:0] hi;
	logic [29:0] prod;

	// seventeen knots of asin(k/16); the last segment is steep, so accuracy is worst near 1
	function automatic logic [17:0] knot(input logic [4:0] k);
		unique case (k)
			5'h00: knot = 18'h00000;
			5'h01: knot = 18'h01003;
			5'h02: knot = 18'h02016;
			5'h03: knot = 18'h03049;
			5'h04: knot = 18'h040B0;
			5'h05: knot = 18'h05158;
			5'h06: knot = 18'h06268;
			5'h07: knot = 18'h073ED;
			5'h08: knot = 18'h0860B;
			5'h09: knot = 18'h098D9;
			5'h0A: knot = 18'h0ACD6;
			5'h0B: knot = 18'h0C212;
			5'h0C: knot = 18'h0D91B;
			5'h0D: knot = 18'h0F2B8;
			5'h0E: knot = 18'h110C0;
			5'h0F: knot = 18'h140D4;
			default: knot = HALF_PI_Q16[17:0];
		endcase
	endfunction

	always_comb begin
		seg          = x_mag[15:12];
		frac         = x_mag[11:0];
		lo           = knot({1'b0, seg});
		hi           = knot({1'b0, seg} + 5'h01);
		prod         = 30'(hi - lo) * 30'(frac);
		st_next      = st_reg;
		st_next.done = start;
		if (start) begin
			st_next.y = x_mag[16] ? HALF_PI_Q16[17:0] : lo + prod[29:12];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign y_mag = st_reg.y;
	assign done  = st_reg.done;
endmodule

/* design/isc_pkg.sv */
// constants and types of the inverse sine / cosine unit: APB map, fields, codes, reset values
// assumes a single pclk domain and an APB master driving the register bus
package isc_pkg;
	localparam int              ADDR_W       = 8;
	localparam logic [7:0]      OFF_CTRL     = 8'h00;
	localparam logic [7:0]      OFF_MODE     = 8'h04;
	localparam logic [7:0]      OFF_SRC      = 8'h08;
	localparam logic [7:0]      OFF_DST      = 8'h0C;
	localparam logic [7:0]      OFF_FLAGS    = 8'h10;
	localparam logic [7:0]      OFF_IRQ_STAT = 8'h14;
	localparam logic [7:0]      OFF_IRQ_MASK = 8'h18;

	// control and mode words: go pulse, rung condition, operation, source and destination types, indirect bits and files
	localparam int              CTRL_GO      = 0;
	localparam int              CTRL_RUNG    = 1;
	localparam int              CTRL_ACOS    = 2;
	localparam int              CTRL_STYPE   = 4;
	localparam int              CTRL_DTYPE   = 6;
	localparam int              MODE_SRC_IND = 0;
	localparam int              MODE_SRC_FILE = 4;
	localparam int              MODE_DST_IND = 8;
	localparam int              MODE_DST_FILE = 12;

	localparam int              FLG_C        = 0;
	localparam int              FLG_V        = 1;
	localparam int              FLG_Z        = 2;
	localparam int              FLG_S        = 3;
	localparam int              FLG_TRAP     = 4;
	localparam int              FLG_BUSY     = 8;
	localparam int              IRQ_DONE     = 0;
	localparam int              IRQ_OVF      = 1;
	localparam int              IRQ_REJ      = 2;
	localparam int              IRQ_W        = 3;

	// file kinds 1..A: status, message, pid, clock, hs counter, pulse out, interrupt, comms, io status, data log
	localparam logic [3:0]      FILE_BARRED_LO = 4'h1;
	localparam logic [3:0]      FILE_BARRED_HI = 4'hA;

	localparam logic [3:0]      FLAGS_NONE   = 4'h0;
	localparam logic [3:0]      FLAGS_V      = 4'h2;
	localparam logic [3:0]      FLAGS_Z      = 4'h4;
	localparam logic [3:0]      FLAGS_S      = 4'h8;
	localparam logic [31:0]     NAN_PATTERN  = 32'h7FFFFFFF;
	localparam logic [31:0]     WORD_SAT     = 32'h00007FFF;
	localparam logic [31:0]     DWORD_SAT    = 32'h7FFFFFFF;

	// fixed point Q16 working format, pi taken as 3.1416
	localparam int              RES_W        = 19;
	localparam logic [16:0]     ONE_Q16      = 17'h10000;
	localparam logic [18:0]     HALF_Q16     = 19'h08000;
	localparam logic [15:0]     HALF_FRAC    = 16'h8000;
	localparam logic [18:0]     HALF_PI_Q16  = 19'h19220;
	localparam logic [7:0]      FLT_EXP_ALL  = 8'hFF;
	localparam logic [7:0]      FLT_EXP_ONE  = 8'h7F;
	localparam logic [7:0]      FLT_EXP_Q16  = 8'h6F;
	localparam logic [7:0]      FLT_SHIFT_Q16 = 8'h86;
	localparam logic [4:0]      FLT_MANT_W   = 5'h17;

	localparam logic [7:0]      RST_CTRL     = 8'h00;
	localparam logic [15:0]     RST_MODE     = 16'h0000;
	localparam logic [31:0]     RST_WORD     = 32'h00000000;
	localparam logic [2:0]      RST_MASK     = 3'h0;

	typedef enum logic [1:0] {ISC_WORD, ISC_DWORD, ISC_FLOAT, ISC_FLOAT_ALT} isc_type_e;
	typedef enum logic [1:0] {ISC_CLS_OK, ISC_CLS_DENORM, ISC_CLS_INVALID} isc_class_e;
	typedef enum logic {ISC_IDLE, ISC_CALC} isc_state_e;
endpackage

/* design/isc_top.sv */
// inverse sine / cosine unit behind an APB slave, with sticky interrupt status
// assumes software keeps ctrl and src steady while busy; such writes are dropped
`timescale 1ns/1ns
module isc_top (
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [isc_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	output logic                            irq
);
	import isc_pkg::*;

	typedef struct packed {
		isc_state_e       fsm;
		logic [7:0]       ctrl;
		logic [15:0]      mode;
		logic [31:0]      src;
		logic [31:0]      dst;
		logic [3:0]       flags;
		logic             trap;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_mask;
		logic [IRQ_W-1:0] irq_seen;
		logic             launch;
		logic             core_go;
		isc_class_e       cls;
		logic             neg;
		logic [16:0]      xmag;
		logic             wb;
		logic             done_p;
		logic [31:0]      prdata;
		logic             pready;
		logic             pslverr;
		logic             irq;
	} isc_top_s;

	isc_top_s         st_reg;
	isc_top_s         st_next;
	logic [17:0]      core_y;
	logic             core_done;
	logic             acc;
	logic             commit;
	logic             busy;
	logic             flt_dst;
	logic             rejected;
	logic [IRQ_W-1:0] ev;
	logic [IRQ_W-1:0] clr;
	logic [31:0]      rd_val;
	isc_type_e        stype;
	isc_type_e        dtype;
	isc_class_e       cls_c;
	logic             neg_c;
	logic [16:0]      xmag_c;
	logic [15:0]      w_abs;
	logic [31:0]      d_abs;
	logic [7:0]       f_exp;
	logic [18:0]      rmag;
	logic             rneg;

	function automatic logic barred(input logic ind, input logic [3:0] file);
		barred = ind && (file >= FILE_BARRED_LO) && (file <= FILE_BARRED_HI);
	endfunction

	function automatic logic [2:0] rnd_half_even(input logic [18:0] mag);
		logic up;
		up            = (mag[15:0] > HALF_FRAC) || ((mag[15:0] == HALF_FRAC) && mag[16]);
		rnd_half_even = mag[18:16] + {2'h0, up};
	endfunction

	function automatic logic [31:0] int_result(input isc_type_e dt, input logic neg, input logic [2:0] mag);
		logic [31:0] v;
		v          = neg ? 32'(-{29'h0, mag}) : {29'h0, mag};
		int_result = (dt == ISC_WORD) ? {16'h0000, v[15:0]} : v;
	endfunction

	// every Q16 value has at most 19 significant bits, so the float is exact and needs no rounding step
	function automatic logic [31:0] flt_result(input logic neg, input logic [18:0] mag);
		logic [4:0]  msb;
		logic [41:0] wide;
		msb = 5'h00;
		for (int i = 0; i < RES_W; i++) begin
			if (mag[i]) begin
				msb = 5'(i);
			end
		end
		wide       = {23'h000000, mag} << (FLT_MANT_W - msb);
		flt_result = {neg, FLT_EXP_Q16 + {3'h0, msb}, wide[22:0]};
	endfunction

	isc_asin_core u_core (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (st_reg.core_go),
		.x_mag   (st_reg.xmag),
		.y_mag   (core_y),
		.done    (core_done)
	);

	always_comb begin
		st_next         = st_reg;
		st_next.wb      = 1'b0;
		st_next.done_p  = 1'b0;
		st_next.core_go = 1'b0;
		st_next.launch  = 1'b0;
		ev              = '0;
		clr             = '0;
		stype           = isc_type_e'(st_reg.ctrl[CTRL_STYPE +: 2]);
		dtype           = isc_type_e'(st_reg.ctrl[CTRL_DTYPE +: 2]);
		flt_dst         = (dtype == ISC_FLOAT) || (dtype == ISC_FLOAT_ALT);
		busy            = (st_reg.fsm != ISC_IDLE) || st_reg.launch;
		rejected        = barred(st_reg.mode[MODE_SRC_IND], st_reg.mode[MODE_SRC_FILE +: 4])
			|| barred(st_reg.mode[MODE_DST_IND], st_reg.mode[MODE_DST_FILE +: 4]);
		w_abs           = st_reg.src[15] ? 16'(-st_reg.src[15:0]) : st_reg.src[15:0];
		d_abs           = st_reg.src[31] ? 32'(-st_reg.src) : st_reg.src;
		f_exp           = st_reg.src[30:23];

		// source to Q1.16 magnitude and sign, whatever its type
		cls_c  = ISC_CLS_OK;
		xmag_c = '0;
		unique case (stype)
			ISC_WORD: begin
				neg_c  = st_reg.src[15];
				xmag_c = w_abs[0] ? ONE_Q16 : 17'h00000;
				if (w_abs > 16'h0001) begin
					cls_c = ISC_CLS_INVALID;
				end
			end
			ISC_DWORD: begin
				neg_c  = st_reg.src[31];
				xmag_c = d_abs[0] ? ONE_Q16 : 17'h00000;
				if (d_abs > 32'h00000001) begin
					cls_c = ISC_CLS_INVALID;
				end
			end
			ISC_FLOAT, ISC_FLOAT_ALT: begin
				neg_c = st_reg.src[31];
				if (f_exp == FLT_EXP_ALL) begin
					cls_c = ISC_CLS_INVALID;
				end else if (f_exp == 8'h00) begin
					// for acos a denormal is simply zero and yields half pi
					if ((st_reg.src[22:0] != 23'h000000) && !st_reg.ctrl[CTRL_ACOS]) begin
						cls_c = ISC_CLS_DENORM;
					end
				end else if ((f_exp > FLT_EXP_ONE) || ((f_exp == FLT_EXP_ONE) && (st_reg.src[22:0] != 23'h000000))) begin
					cls_c = ISC_CLS_INVALID;
				end else if (f_exp == FLT_EXP_ONE) begin
					xmag_c = ONE_Q16;
				end else begin
					xmag_c = 17'({1'b1, st_reg.src[22:0]} >> (FLT_SHIFT_Q16 - f_exp));
				end
			end
		endcase
		// a tiny negative source collapses to +0 and must not raise the sign flag
		neg_c = neg_c && (xmag_c != 17'h00000);

		if (st_reg.ctrl[CTRL_ACOS]) begin
			rmag = st_reg.neg ? HALF_PI_Q16 + {1'b0, core_y} : HALF_PI_Q16 - {1'b0, core_y};
			rneg = 1'b0;
		end else begin
			rmag = {1'b0, core_y};
			rneg = st_reg.neg;
		end

		// APB: one wait state, effects only at the edge that completes the access
		acc              = psel && penable;
		commit           = acc && st_reg.pready;
		st_next.pready   = acc && !st_reg.pready;
		st_next.pslverr  = 1'b0;
		unique case (paddr)
			OFF_CTRL:     rd_val = {24'h000000, st_reg.ctrl};
			OFF_MODE:     rd_val = {16'h0000, st_reg.mode};
			OFF_SRC:      rd_val = st_reg.src;
			OFF_DST:      rd_val = st_reg.dst;
			OFF_FLAGS:    rd_val = {23'h000000, busy, 3'h0, st_reg.trap, st_reg.flags};
			OFF_IRQ_STAT: rd_val = {29'h00000000, st_reg.irq_stat};
			OFF_IRQ_MASK: rd_val = {29'h00000000, st_reg.irq_mask};
			default:      begin
				rd_val          = RST_WORD;
				st_next.pslverr = acc && !st_reg.pready;
			end
		endcase
		if (acc && !st_reg.pready && !pwrite) begin
			st_next.prdata   = rd_val;
			st_next.irq_seen = (paddr == OFF_IRQ_STAT) ? st_reg.irq_stat : '0;
		end
		if (commit && !pwrite && (paddr == OFF_IRQ_STAT)) begin
			// only bits that were actually returned get cleared
			clr = st_reg.irq_seen;
		end
		if (commit && pwrite) begin
			unique case (paddr)
				OFF_CTRL: begin
					if (!busy) begin
						st_next.ctrl   = {pwdata[7:1], 1'b0};
						st_next.launch = pwdata[CTRL_GO];
					end
				end
				OFF_MODE:     st_next.mode = pwdata[15:0];
				OFF_SRC: begin
					if (!busy) begin
						st_next.src = pwdata;
					end
				end
				OFF_FLAGS: begin
					if (!pwdata[FLG_TRAP]) begin
						st_next.trap = 1'b0;
					end
				end
				OFF_IRQ_MASK: st_next.irq_mask = pwdata[IRQ_W-1:0];
				default:      st_next.ctrl = st_reg.ctrl;
			endcase
		end

		// engine runs after the bus so that a hardware set beats a software clear
		unique case (st_reg.fsm)
			ISC_IDLE: begin
				if (st_reg.launch) begin
					if (!st_reg.ctrl[CTRL_RUNG]) begin
						st_next.done_p = 1'b1;
					end else if (rejected) begin
						st_next.done_p = 1'b1;
						ev[IRQ_REJ]    = 1'b1;
					end else begin
						st_next.cls  = cls_c;
						st_next.neg  = neg_c;
						st_next.xmag = xmag_c;
						if (cls_c == ISC_CLS_OK) begin
							st_next.core_go = 1'b1;
							st_next.fsm     = ISC_CALC;
						end else if (cls_c == ISC_CLS_DENORM) begin
							st_next.dst    = RST_WORD;
							st_next.flags  = FLAGS_Z;
							st_next.wb     = 1'b1;
							st_next.done_p = 1'b1;
						end else begin
							st_next.dst    = flt_dst ? NAN_PATTERN : (dtype == ISC_WORD ? WORD_SAT : DWORD_SAT);
							st_next.flags  = FLAGS_V;
							st_next.trap   = 1'b1;
							st_next.wb     = 1'b1;
							st_next.done_p = 1'b1;
							ev[IRQ_OVF]    = 1'b1;
						end
					end
				end
			end
			ISC_CALC: begin
				if (core_done) begin
					st_next.fsm    = ISC_IDLE;
					st_next.wb     = 1'b1;
					st_next.done_p = 1'b1;
					if (!flt_dst) begin
						if (rmag < HALF_Q16) begin
							st_next.dst   = RST_WORD;
							st_next.flags = FLAGS_Z;
						end else begin
							st_next.dst   = int_result(dtype, rneg, rnd_half_even(rmag));
							st_next.flags = rneg ? FLAGS_S : FLAGS_NONE;
						end
					end else if (rmag == 19'h00000) begin
						st_next.dst   = RST_WORD;
						st_next.flags = FLAGS_Z;
					end else begin
						st_next.dst   = flt_result(rneg, rmag);
						st_next.flags = rneg ? FLAGS_S : FLAGS_NONE;
					end
				end
			end
		endcase
		ev[IRQ_DONE]     = st_next.done_p;
		st_next.irq_stat = (st_reg.irq_stat & ~clr) | ev;
		st_next.irq      = |(st_next.irq_stat & st_next.irq_mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata  = st_reg.prdata;
	assign pready  = st_reg.pready;
	assign pslverr = st_reg.pslverr;
	assign irq     = st_reg.irq;

	denorm_zero_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		st_reg.wb && (st_reg.cls == ISC_CLS_DENORM)
		|-> (st_reg.dst == RST_WORD) && (st_reg.flags == FLAGS_Z) && (st_reg.trap == $past(st_reg.trap)))
		else $error("denormal source did not give zero with zero flag only");

	underflow_zero_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		st_reg.wb && flt_dst && (st_reg.dst[30:0] == 31'h00000000)
		|-> !st_reg.dst[31] && (st_reg.flags == FLAGS_Z))
		else $error("zero float result is not positive zero with zero flag");

	// the core result still stands in the write-back cycle, so the threshold is checked on it
	small_int_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		st_reg.wb && !flt_dst && (st_reg.cls == ISC_CLS_OK) && (rmag < HALF_Q16)
		|-> (st_reg.dst == RST_WORD) && (st_reg.flags == FLAGS_Z))
		else $error("integer result below one half is not zero with zero flag");

	float_sign_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		st_reg.wb && flt_dst && (st_reg.cls == ISC_CLS_OK) && (rmag != 19'h00000)
		|-> (st_reg.flags == ((st_reg.neg && !st_reg.ctrl[CTRL_ACOS]) ? FLAGS_S : FLAGS_NONE))
			&& (st_reg.dst[31] == st_reg.flags[FLG_S]))
		else $error("float result sign flag does not follow the source sign");

	nan_float_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		st_reg.wb && flt_dst && (st_reg.cls == ISC_CLS_INVALID)
		|-> (st_reg.dst == NAN_PATTERN) && (st_reg.flags == FLAGS_V) && st_reg.trap)
		else $error("float overflow did not give the nan pattern with V and trap");

	int_sat_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		st_reg.wb && !flt_dst && (st_reg.cls == ISC_CLS_INVALID)
		|-> (st_reg.dst == ((dtype == ISC_WORD) ? WORD_SAT : DWORD_SAT)) && (st_reg.flags == FLAGS_V))
		else $error("integer overflow did not saturate to the positive maximum");

	trap_cause_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(st_reg.trap) |-> st_reg.wb && st_reg.flags[FLG_V])
		else $error("trap bit rose without an overflow");

	trap_keep_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		st_reg.trap && !(commit && pwrite && (paddr == OFF_FLAGS) && !pwdata[FLG_TRAP])
		|=> st_reg.trap)
		else $error("trap bit cleared without a software clear");

	reject_hold_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		st_reg.launch && st_reg.ctrl[CTRL_RUNG] && rejected
		|=> !st_reg.wb && $stable(st_reg.dst) && st_reg.irq_stat[IRQ_REJ])
		else $error("barred indirect operand was not rejected");

	rung_false_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		st_reg.launch && !st_reg.ctrl[CTRL_RUNG]
		|=> !st_reg.wb && $stable(st_reg.dst) && $stable(st_reg.flags) ##1 !st_reg.wb)
		else $error("false rung changed the destination or flags");

	done_bound_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		st_reg.launch |-> ##[1:3] st_reg.done_p)
		else $error("operation did not finish within three cycles");
endmodule

/* dv/tb_isc_top.sv */
// self-checking bench of the inverse sine / cosine unit, driven through its APB port
// assumes isc_top answers every APB access with one wait state and sets busy from the go commit
`timescale 1ns/1ns
module tb_isc_top;
	import isc_pkg::*;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic [31:0] rd;
	logic        last_err;
	logic [7:0]  offs [7];
	int          errors = 0;
	int          checks_done = 0;

	isc_top i_dut (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.irq     (irq)
	);

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	task automatic end_sim();
		if (errors == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one transfer: setup, access held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk("pready", 32'(pready), 32'h1);
		rd = prdata;
		last_err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic [7:0] ctl(input logic acos, input isc_type_e st, input isc_type_e dt);
		return {dt, st, 1'b0, acos, 2'b11};
	endfunction

	// leaves the final flags word in rd
	task automatic run_op(input logic [7:0] ctrl, input logic [31:0] src);
		int n;
		n = 0;
		apb(1'b1, OFF_SRC, src);
		apb(1'b1, OFF_CTRL, {24'h0, ctrl});
		do begin
			apb(1'b0, OFF_FLAGS, 32'h0);
			n++;
		end while (rd[FLG_BUSY] !== 1'b0 && n < 20);
		chk("busy", 32'(rd[FLG_BUSY]), 32'h0);
	endtask

	// float results come from an approximating core, so msk keeps only sign and exponent there
	task automatic op_chk(input logic [7:0] ctrl, input logic [31:0] src, input logic [31:0] msk,
		input logic [31:0] dexp, input logic [4:0] fexp);
		run_op(ctrl, src);
		chk("flags", rd & 32'h1F, {27'h0, fexp});
		apb(1'b0, OFF_DST, 32'h0);
		chk("dst", rd & msk, dexp);
	endtask

	// irq is registered in the same cycle as the status bits; wait a few edges before sampling it
	task automatic irq_is(input logic e);
		repeat (3) @(posedge pclk);
		#1;
		chk("irq", 32'(irq), 32'(e));
	endtask

	initial begin
		repeat (50000) @(posedge pclk);
		errors++;
		end_sim();
	end

	initial begin
		presetn = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h00000000;
		offs    = '{OFF_CTRL, OFF_MODE, OFF_SRC, OFF_DST, OFF_FLAGS, OFF_IRQ_STAT, OFF_IRQ_MASK};
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		foreach (offs[i]) begin
			apb(1'b0, offs[i], 32'h0);
			chk("reset value", rd, RST_WORD);
		end
		apb(1'b1, 8'h1C, 32'hFFFFFFFF);
		chk("slverr write", 32'(last_err), 32'h1);
		apb(1'b0, 8'h1C, 32'h0);
		chk("unmapped read", rd, 32'h0);
		chk("slverr read", 32'(last_err), 32'h1);

		// interrupt: raised, cleared by read, then masked
		apb(1'b1, OFF_IRQ_MASK, 32'h7);
		apb(1'b0, OFF_IRQ_MASK, 32'h0);
		chk("mask", rd, 32'h7);
		op_chk(ctl(0, ISC_WORD, ISC_WORD), 32'h5A5A0001, 32'hFFFFFFFF, 32'h2, 5'h00);
		irq_is(1'b1);
		apb(1'b0, OFF_IRQ_STAT, 32'h0);
		chk("status done", rd, 32'h1);
		irq_is(1'b0);
		op_chk(ctl(0, ISC_WORD, ISC_WORD), 32'h00000002, 32'hFFFFFFFF, WORD_SAT, 5'h12);
		irq_is(1'b1);
		apb(1'b0, OFF_IRQ_STAT, 32'h0);
		chk("status ovf", rd, 32'h3);
		apb(1'b1, OFF_IRQ_MASK, 32'h0);
		op_chk(ctl(0, ISC_DWORD, ISC_DWORD), 32'hFFFFFFFD, 32'hFFFFFFFF, DWORD_SAT, 5'h12);
		irq_is(1'b0);
		apb(1'b0, OFF_IRQ_STAT, 32'h0);
		chk("masked status", rd, 32'h3);

		// conversions, thresholds and invalid sources
		op_chk(ctl(0, ISC_DWORD, ISC_DWORD), 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFE, 5'h18);
		op_chk(ctl(0, ISC_FLOAT, ISC_WORD), 32'hBF800000, 32'hFFFFFFFF, 32'h0000FFFE, 5'h18);
		op_chk(ctl(0, ISC_FLOAT, ISC_WORD), 32'hBF19999A, 32'hFFFFFFFF, 32'h0000FFFF, 5'h18);
		op_chk(ctl(0, ISC_FLOAT, ISC_DWORD), 32'h3ECCCCCD, 32'hFFFFFFFF, 32'h0, 5'h14);
		op_chk(ctl(0, ISC_FLOAT, ISC_WORD), 32'h3F000000, 32'hFFFFFFFF, 32'h1, 5'h10);
		op_chk(ctl(0, ISC_FLOAT, ISC_FLOAT), 32'hBF000000, 32'hFF800000, 32'hBF000000, 5'h18);
		op_chk(ctl(0, ISC_FLOAT, ISC_FLOAT), 32'h3F000000, 32'hFF800000, 32'h3F000000, 5'h10);
		op_chk(ctl(0, ISC_FLOAT, ISC_WORD), 32'h7FC00000, 32'hFFFFFFFF, WORD_SAT, 5'h12);
		op_chk(ctl(0, ISC_FLOAT, ISC_DWORD), 32'h7F800000, 32'hFFFFFFFF, DWORD_SAT, 5'h12);
		op_chk(ctl(0, ISC_FLOAT, ISC_FLOAT), 32'h7FC00000, 32'hFFFFFFFF, NAN_PATTERN, 5'h12);
		op_chk(ctl(0, ISC_FLOAT, ISC_FLOAT_ALT), 32'h3FC00000, 32'hFFFFFFFF, NAN_PATTERN, 5'h12);
		op_chk(ctl(0, ISC_FLOAT, ISC_FLOAT), 32'h00000001, 32'hFFFFFFFF, 32'h0, 5'h14);

		// trap cleared by software, not set again without overflow
		apb(1'b1, OFF_FLAGS, 32'h0);
		op_chk(ctl(0, ISC_FLOAT, ISC_FLOAT), 32'hB5800000, 32'hFFFFFFFF, 32'h0, 5'h04);
		op_chk(ctl(1, ISC_FLOAT, ISC_FLOAT), 32'h3F800000, 32'hFFFFFFFF, 32'h0, 5'h04);
		op_chk(ctl(1, ISC_FLOAT, ISC_FLOAT), 32'h3F000000, 32'hFF800000, 32'h3F800000, 5'h00);
		op_chk(ctl(1, ISC_WORD, ISC_WORD), 32'h0000FFFF, 32'hFFFFFFFF, 32'h3, 5'h00);
		op_chk(ctl(1, ISC_WORD, ISC_DWORD), 32'h00000000, 32'hFFFFFFFF, 32'h2, 5'h00);

		// rung false: an overflowing source must leave dst and flags as they were
		op_chk(ctl(0, ISC_WORD, ISC_WORD) & 8'hFD, 32'h00000002, 32'hFFFFFFFF, 32'h2, 5'h00);
		apb(1'b1, OFF_DST, 32'hDEADBEEF);
		apb(1'b0, OFF_DST, 32'h0);
		chk("dst read only", rd, 32'h2);

		// every barred file kind through an indirect source, one through the destination
		apb(1'b0, OFF_IRQ_STAT, 32'h0);
		for (int code = 1; code <= 11; code++) begin
			if (code <= 10) begin
				apb(1'b1, OFF_MODE, 32'(code << MODE_SRC_FILE) | 32'h1);
			end else begin
				apb(1'b1, OFF_MODE, (32'h5 << MODE_DST_FILE) | (32'h1 << MODE_DST_IND));
			end
			op_chk(ctl(0, ISC_WORD, ISC_WORD), 32'h0000FFFF, 32'hFFFFFFFF, 32'h2, 5'h00);
			apb(1'b0, OFF_IRQ_STAT, 32'h0);
			chk("status rej", rd, 32'h5);
		end
		apb(1'b1, OFF_MODE, 32'h1);
		op_chk(ctl(0, ISC_WORD, ISC_WORD), 32'h0000FFFF, 32'hFFFFFFFF, 32'h0000FFFE, 5'h08);

		// reset after the last operation has finished must bring every register back to zero
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		foreach (offs[i]) begin
			apb(1'b0, offs[i], 32'h0);
			chk("value after second reset", rd, RST_WORD);
		end
		end_sim();
	end
endmodule
